// *** core/lpd_defs.svh ***
// Offsets, field positions, reset values and timing counts of the LCD power block
`ifndef LPD_DEFS_SVH
`define LPD_DEFS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define LPD_IDX_W 10
`define LPD_IDX_PWR_CTRL 10'h01a
`define LPD_IDX_DP_BASE 10'h200
`define LPD_IDX_DP_LAST 10'h22b

// ----------------------------------------------------------------
// Display RAM geometry
// ----------------------------------------------------------------
`define LPD_DP_STRIDE 8
`define LPD_DP_LINE_BYTES 5
`define LPD_DP_LINES 6
`define LPD_DP_BYTES 40

// ----------------------------------------------------------------
// Power control fields and reset value
// ----------------------------------------------------------------
`define LPD_PWR_RESET 8'h7f
`define LPD_CP_SEL_MSB 2
`define LPD_CP_SEL_LSB 0
`define LPD_PUMP_EN_BIT 3
`define LPD_REG_EN_BIT 4
`define LPD_REG_LVL_MSB 6
`define LPD_REG_LVL_LSB 5
`define LPD_CP_SEL_SLOW_CLOCK_FREQ 3'h7
`define LPD_CP_SEL_TOP_TAP 3'h6

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LPD_CLK_PERIOD_NS 40
`define LPD_SLOW_CLK_HZ 32768
`define LPD_SLOW_HALF_NS (1000000000 / (2 * `LPD_SLOW_CLK_HZ))
`define LPD_SLOW_HALF_CYC (`LPD_SLOW_HALF_NS / `LPD_CLK_PERIOD_NS)
`define LPD_TAP_STAGES 7

`endif

// *** core/lpd_pkg.sv ***
// Types shared by the LCD power and display RAM block
package lpd_pkg;

	// Power control register layout, bit 7 reserved
	typedef struct packed
	{
		logic rsvd;
		logic [1:0] reg_level;
		logic reg_en;
		logic pump_en;
		logic [2:0] cp_sel;
	} lpd_pwr_ctrl_t;

	// One display RAM write, storage index and byte
	typedef struct packed
	{
		logic en;
		logic [5:0] addr;
		logic [7:0] data;
	} lpd_dp_wr_t;

	// Bus slave handshake states
	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b01,
		ST_ACK = 2'b10
	} lpd_bus_st_t;

endpackage

// *** core/lpd_slow_div.sv ***
// Slow clock generator and its binary divider chain
`timescale 1ns/10ps
`include "lpd_defs.svh"
module lpd_slow_div
#(
	parameter int HALF_CYC = `LPD_SLOW_HALF_CYC,
	parameter int STAGES = `LPD_TAP_STAGES
)
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	output logic o_slow_clk,
	output logic [STAGES-1:0] o_taps
);

	// Half period counter of the slow clock
	logic [9:0] half_cnt_reg;
	// Slow clock level
	logic slow_reg;
	// Divider chain, stage k runs at slow / 2^(k+1)
	logic [STAGES-1:0] chain_reg;

	// ----------------------------------------------------------------
	// Half period enable pulse
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			half_cnt_reg <= 10'h000;
		else if (half_cnt_reg == 10'(HALF_CYC - 1))
			half_cnt_reg <= 10'h000;
		else
			half_cnt_reg <= half_cnt_reg + 10'h001;
	end

	// ----------------------------------------------------------------
	// Slow clock level and chain, chain steps on slow rising edge
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			slow_reg <= 1'b0;
			chain_reg <= '0;
		end
		else if (half_cnt_reg == 10'(HALF_CYC - 1))
		begin
			slow_reg <= ~slow_reg;
			// Count on the low-to-high turn only
			if (!slow_reg)
				chain_reg <= chain_reg + STAGES'(1);
		end
	end

	assign o_slow_clk = slow_reg;
	assign o_taps = chain_reg;

endmodule

// *** core/lpd_display_ram.sv ***
// Display RAM storage with a flat view of every byte for the panel
`timescale 1ns/10ps
`include "lpd_defs.svh"
module lpd_display_ram
	import lpd_pkg::*;
#(
	parameter int DEPTH = `LPD_DP_BYTES
)
(
	input wire logic i_clk,
	input wire lpd_dp_wr_t i_wr,
	output logic [DEPTH*8-1:0] o_bytes
);

	// Storage; no reset, contents are undefined until software fills them
	logic [7:0] mem_reg [DEPTH];

	// ----------------------------------------------------------------
	// Write port
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (i_wr.en)
			mem_reg[i_wr.addr] <= i_wr.data;
	end

	// ----------------------------------------------------------------
	// Every byte visible at once, no latching stage in between
	// ----------------------------------------------------------------
	always_comb
	begin
		for (int i = 0; i < DEPTH; i++)
			o_bytes[i*8 +: 8] = mem_reg[i];
	end

endmodule

// *** core/lpd_top.sv ***
// LCD power control register and display RAM behind an Avalon-MM slave
//
// Notes on behaviour
// - Bits 2:0 pick pump clock, reset 111
// - Codes 000-110 divide slow clock 128..2
// - Bit 3 enables charge pump, reset on
// - Bit 4 enables regulator, reset on
// - Bits 6:5 regulator level, reset 11
// - Power control at index 1A, read/write
// - Each common line strides eight bytes
// - Six lines, last valid index 22B
// - RAM writes reach panel immediately
`timescale 1ns/10ps
`include "lpd_defs.svh"
module lpd_top
	import lpd_pkg::*;
#(
	parameter int LINES = `LPD_DP_LINES,
	parameter int LINE_BYTES = `LPD_DP_LINE_BYTES,
	parameter int DP_BYTES = `LPD_DP_BYTES,
	parameter int HALF_CYC = `LPD_SLOW_HALF_CYC
)
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [11:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	output logic o_pump_clk,
	output logic o_pump_en,
	output logic o_reg_en,
	output logic [1:0] o_reg_level,
	output logic [DP_BYTES*8-1:0] o_panel_data
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	// Bus handshake state
	lpd_bus_st_t st_reg;
	lpd_bus_st_t st_next;
	// Power control register
	lpd_pwr_ctrl_t pwr_reg;
	// Registered read data
	logic [31:0] rdata_reg;
	// Registered pump clock output
	logic pump_clk_reg;
	// Word index taken from the byte address
	logic [`LPD_IDX_W-1:0] idx;
	// Request present on the bus
	logic req;
	// Display RAM decode of the current index
	logic dp_hit;
	logic [5:0] dp_addr;
	// Byte picked for a read
	logic [7:0] rd_byte;
	// Display RAM write towards storage
	lpd_dp_wr_t dp_wr;
	// Slow clock and divider taps
	logic slow_clk;
	logic [`LPD_TAP_STAGES-1:0] taps;
	// Pump clock before the enable gate
	logic pump_sel;

	// ----------------------------------------------------------------
	// Display RAM decode
	// ----------------------------------------------------------------
	// Returns {hit, storage index}; columns past the fifth byte are holes
	function automatic logic [6:0] dp_decode(input logic [`LPD_IDX_W-1:0] i);
		logic [`LPD_IDX_W-1:0] off;
		logic [2:0] line;
		logic [2:0] col;
		logic hit;
		off = i - `LPD_IDX_DP_BASE;
		line = off[5:3];
		col = off[2:0];
		hit = (i >= `LPD_IDX_DP_BASE) && (i <= `LPD_IDX_DP_LAST)
			&& (col < 3'(LINE_BYTES)) && (line < 3'(LINES));
		return {hit, 6'(line) * 6'(LINE_BYTES) + 6'(col)};
	endfunction

	assign idx = i_avs_address[11:2];
	assign req = i_avs_read | i_avs_write;

	// Stride of eight per line, five stored bytes each, four on the last line
	// Nothing answers past the last valid index
	always_comb
	begin
		{dp_hit, dp_addr} = dp_decode(idx);
	end

	// ----------------------------------------------------------------
	// Bus handshake: one wait state, then the answer
	// ----------------------------------------------------------------
	// Next state of the handshake
	always_comb
	begin
		st_next = st_reg;
		unique case (st_reg)
			// A fresh request always gets one wait state
			ST_IDLE:
				if (req)
					st_next = ST_ACK;
			// Answer cycle, always back to idle
			ST_ACK:
				st_next = ST_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			st_reg <= ST_IDLE;
		else
			st_reg <= st_next;
	end

	// Waitrequest drops in the answer cycle only
	assign o_avs_waitrequest = req && (st_reg == ST_IDLE);

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// Byte from the register or the panel image; holes read zero
	always_comb
	begin
		rd_byte = 8'h00;
		if (idx == `LPD_IDX_PWR_CTRL)
			rd_byte = {1'b0, pwr_reg[6:0]};
		else if (dp_hit)
			rd_byte = o_panel_data[dp_addr*8 +: 8];
	end

	// Captured in the wait state so the answer comes from a flop
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			rdata_reg <= 32'h0000_0000;
		else if (st_reg == ST_IDLE && i_avs_read)
			rdata_reg <= {24'h00_0000, rd_byte};
	end

	assign o_avs_readdata = rdata_reg;

	// ----------------------------------------------------------------
	// Power control register
	// ----------------------------------------------------------------
	// Written at the answer edge; only lane 0 carries data
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			pwr_reg <= `LPD_PWR_RESET;
		else if (st_reg == ST_ACK && i_avs_write && i_avs_byteenable[0]
			&& idx == `LPD_IDX_PWR_CTRL)
		begin
			// Reserved bit stays zero
			pwr_reg <= {1'b0, i_avs_writedata[6:0]};
		end
	end

	// Level fields straight to the analog side
	assign o_pump_en = pwr_reg.pump_en;
	assign o_reg_en = pwr_reg.reg_en;
	assign o_reg_level = pwr_reg.reg_level;

	// ----------------------------------------------------------------
	// Display RAM
	// ----------------------------------------------------------------
	// Write goes straight into the storage that feeds the panel
	always_comb
	begin
		dp_wr.en = (st_reg == ST_ACK) && i_avs_write && i_avs_byteenable[0]
			&& dp_hit;
		dp_wr.addr = dp_addr;
		dp_wr.data = i_avs_writedata[7:0];
	end

	// Storage and panel image
	lpd_display_ram #(
		.DEPTH(DP_BYTES)
	) u_display_ram (
		.i_clk(i_clk),
		.i_wr(dp_wr),
		.o_bytes(o_panel_data)
	);

	// ----------------------------------------------------------------
	// Charge pump clock
	// ----------------------------------------------------------------
	// Slow clock and its divider chain
	lpd_slow_div #(
		.HALF_CYC(HALF_CYC),
		.STAGES(`LPD_TAP_STAGES)
	) u_slow_div (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.o_slow_clk(slow_clk),
		.o_taps(taps)
	);

	// Code 111 is the raw slow clock, lower codes take deeper taps
	always_comb
	begin
		if (pwr_reg.cp_sel == `LPD_CP_SEL_SLOW_CLOCK_FREQ)
			pump_sel = slow_clk;
		else
			pump_sel = taps[`LPD_CP_SEL_TOP_TAP - pwr_reg.cp_sel];
	end

	// Registered so the pin never glitches on a code change
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
			pump_clk_reg <= 1'b0;
		else
			pump_clk_reg <= pump_sel && pwr_reg.pump_en;
	end

	assign o_pump_clk = pump_clk_reg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Byte of line/column in the panel image
	function automatic logic [7:0] panel_byte(input logic [5:0] a);
		return o_panel_data[a*8 +: 8];
	endfunction

	// Answer cycle of a write
	logic wr_ack;
	logic rd_ack;
	assign wr_ack = i_avs_write && !o_avs_waitrequest;
	assign rd_ack = i_avs_read && !o_avs_waitrequest;

	property p_cp_reset;
		@(posedge i_clk) disable iff (!i_rst_n)
		$rose(i_rst_n) |-> pwr_reg.cp_sel == 3'h7 ##1 pwr_reg.cp_sel == 3'h7
			|| $past(wr_ack);
	endproperty
	a_cp_reset: assert property (p_cp_reset)
		else $error("pump clock select not 111 after reset");

	property p_tap_div128;
		@(posedge i_clk) disable iff (!i_rst_n)
		(pwr_reg.cp_sel == 3'h0 && pwr_reg.pump_en && $stable(pwr_reg))
			|=> o_pump_clk == $past(taps[6]);
	endproperty
	a_tap_div128: assert property (p_tap_div128)
		else $error("code 000 does not follow the deepest tap");

	property p_pump_reset;
		@(posedge i_clk) disable iff (!i_rst_n)
		$rose(i_rst_n) |-> o_pump_en && o_reg_en;
	endproperty
	a_pump_reset: assert property (p_pump_reset)
		else $error("pump or regulator off after reset");

	property p_reg_en_write;
		@(posedge i_clk) disable iff (!i_rst_n)
		(wr_ack && idx == 10'h01a && i_avs_byteenable[0])
			|=> o_reg_en == $past(i_avs_writedata[4]);
	endproperty
	a_reg_en_write: assert property (p_reg_en_write)
		else $error("regulator enable did not take bit 4");

	property p_level_reset;
		@(posedge i_clk) disable iff (!i_rst_n)
		$rose(i_rst_n) |-> o_reg_level == 2'h3;
	endproperty
	a_level_reset: assert property (p_level_reset)
		else $error("regulator level not 11 after reset");

	property p_pwr_readback;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_avs_read && o_avs_waitrequest && idx == 10'h01a)
			|=> o_avs_readdata == {25'h0, pwr_reg[6:0]} && !o_avs_waitrequest;
	endproperty
	a_pwr_readback: assert property (p_pwr_readback)
		else $error("power control read back wrong");

	property p_hole_reads_zero;
		@(posedge i_clk) disable iff (!i_rst_n)
		(rd_ack && idx >= 10'h200 && idx[2:0] > 3'h4)
			|-> o_avs_readdata == 32'h0;
	endproperty
	a_hole_reads_zero: assert property (p_hole_reads_zero)
		else $error("stride hole answered with data");

	property p_past_last_zero;
		@(posedge i_clk) disable iff (!i_rst_n)
		(rd_ack && idx > 10'h22b) |-> o_avs_readdata == 32'h0;
	endproperty
	a_past_last_zero: assert property (p_past_last_zero)
		else $error("index past display RAM answered with data");

	property p_panel_now;
		@(posedge i_clk) disable iff (!i_rst_n)
		(wr_ack && i_avs_byteenable[0] && dp_hit)
			|=> panel_byte($past(dp_addr)) == $past(i_avs_writedata[7:0]);
	endproperty
	a_panel_now: assert property (p_panel_now)
		else $error("display RAM write not on panel next cycle");

	property p_pump_off_low;
		@(posedge i_clk) disable iff (!i_rst_n)
		!o_pump_en [*2] |-> !o_pump_clk;
	endproperty
	a_pump_off_low: assert property (p_pump_off_low)
		else $error("pump clock moves while pump disabled");

endmodule

// *** test/lpd_top_tb.sv ***
// Self-checking testbench for the LCD power and display RAM block
`timescale 1ns/10ps
module lpd_top_tb;
	import lpd_pkg::*;

	// ----
	// Row of an ordinary write-then-read case
	// ----
	typedef struct
	{
		logic [11:0] addr;
		logic [7:0] wdat;
		logic be;
		logic [7:0] exp;
		int pix;
	} lpd_row_t;

	localparam int HALF = 2; // Short slow-clock half period keeps the pump scan quick
	localparam int LIMIT = 20000; // Generous ceiling for the whole run

	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [11:0] i_avs_address = 12'h000;
	logic i_avs_read = 1'b0;
	logic i_avs_write = 1'b0;
	logic [31:0] i_avs_writedata = 32'h0;
	logic [3:0] i_avs_byteenable = 4'h0;
	logic [31:0] o_avs_readdata;
	logic o_avs_waitrequest;
	logic o_pump_clk;
	logic o_pump_en;
	logic o_reg_en;
	logic [1:0] o_reg_level;
	logic [319:0] o_panel_data;
	int n_errors = 0;
	int n_tests = 0;
	int cyc = 0;
	logic [7:0] q;
	int p;
	int hi;
	lpd_row_t rows[8];

	// Clock generator, 40 ns period
	always #20 i_clk = ~i_clk;

	lpd_top #(.HALF_CYC(HALF)) lpd_top_inst
	(
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_avs_address(i_avs_address),
		.i_avs_read(i_avs_read),
		.i_avs_write(i_avs_write),
		.i_avs_writedata(i_avs_writedata),
		.i_avs_byteenable(i_avs_byteenable),
		.o_avs_readdata(o_avs_readdata),
		.o_avs_waitrequest(o_avs_waitrequest),
		.o_pump_clk(o_pump_clk),
		.o_pump_en(o_pump_en),
		.o_reg_en(o_reg_en),
		.o_reg_level(o_reg_level),
		.o_panel_data(o_panel_data)
	);

	// ----
	// Reporting
	// ----
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Compare one value, report at once on mismatch
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Hang guard
	always @(posedge i_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == LIMIT)
		begin
			n_errors++;
			print_verdict();
		end
	end

	// ----
	// Avalon-MM master, one access; entered just after a rising edge
	// ----
	task automatic bus(input logic rd, input logic [11:0] a, input logic [7:0] d,
		input logic be, output logic [7:0] r);
		i_avs_read <= rd;
		i_avs_write <= !rd;
		i_avs_address <= a;
		i_avs_writedata <= {24'h0, d};
		i_avs_byteenable <= {3'h0, be};
		// Hold the request until waitrequest is seen low at an edge
		do
			@(posedge i_clk);
		while (o_avs_waitrequest !== 1'b0);
		r = o_avs_readdata[7:0];
		if (rd)
			chk("readdata upper", 32'h0, {o_avs_readdata[31:8], 8'h0});
		i_avs_read <= 1'b0;
		i_avs_write <= 1'b0;
		// Idle edge so the next call never reassigns in this time step
		@(posedge i_clk);
	endtask

	// Read and compare one byte
	task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
		bus(1'b1, a, 8'h00, 1'b0, q);
		chk("read byte", {24'h0, e}, {24'h0, q});
	endtask

	// Period of the pump clock in i_clk cycles, rise to rise, bounded wait
	task automatic pump_period(output int per);
		logic prev;
		int rises;
		int t0;
		// One edge first, so the register already shows the new code's source
		@(posedge i_clk);
		prev = o_pump_clk;
		rises = 0;
		t0 = 0;
		per = -1;
		for (int n = 0; n < 1500 && per < 0; n++)
		begin
			@(posedge i_clk);
			if (prev === 1'b0 && o_pump_clk === 1'b1)
			begin
				rises++;
				if (rises == 1)
					t0 = n;
				else
					per = n - t0;
			end
			prev = o_pump_clk;
		end
	endtask

	// ----
	// Main sequence
	// ----
	initial
	begin
		// Power control, RAM bytes, holes, unmapped place, ignored byte lane
		rows[0] = '{12'h068, 8'h95, 1'b1, 8'h15, -1};
		rows[1] = '{12'h068, 8'h6a, 1'b1, 8'h6a, -1};
		rows[2] = '{12'h068, 8'h00, 1'b0, 8'h6a, -1};
		rows[3] = '{12'h800, 8'ha5, 1'b1, 8'ha5, 0};
		rows[4] = '{12'h824, 8'h5a, 1'b1, 8'h5a, 6};
		rows[5] = '{12'h8ac, 8'h3c, 1'b1, 8'h3c, 28};
		rows[6] = '{12'h814, 8'h11, 1'b1, 8'h00, -1};
		rows[7] = '{12'h8b0, 8'h22, 1'b1, 8'h00, -1};
		repeat (20) @(posedge i_clk);
		i_rst_n <= 1'b1;
		@(posedge i_clk);
		// Reset state of power outputs and register
		chk("pump_en", 32'h1, {31'h0, o_pump_en});
		chk("reg_en", 32'h1, {31'h0, o_reg_en});
		chk("reg_level", 32'h3, {30'h0, o_reg_level});
		rd_chk(12'h068, 8'h7f);
		pump_period(p);
		chk("pump period 7", 2 * HALF, p);
		rd_chk(12'h004, 8'h00);
		// Row loop: write, panel image one edge later, then read back
		foreach (rows[i])
		begin
			bus(1'b0, rows[i].addr, rows[i].wdat, rows[i].be, q);
			@(posedge i_clk);
			if (rows[i].pix >= 0)
				chk("panel", {24'h0, rows[i].exp},
					{24'h0, o_panel_data[rows[i].pix*8 +: 8]});
			rd_chk(rows[i].addr, rows[i].exp);
		end
		// Power down in order: pump off first, regulator after
		bus(1'b0, 12'h068, 8'h17, 1'b1, q);
		hi = 0;
		repeat (300)
		begin
			@(posedge i_clk);
			if (o_pump_clk !== 1'b0)
				hi++;
		end
		chk("pump clk off", 32'h0, hi);
		chk("pump_en off", 32'h0, {31'h0, o_pump_en});
		bus(1'b0, 12'h068, 8'h07, 1'b1, q);
		chk("reg_en off", 32'h0, {31'h0, o_reg_en});
		// Power up order, then scan every divider code and level
		bus(1'b0, 12'h068, 8'h10, 1'b1, q);
		chk("reg_en on", 32'h1, {31'h0, o_reg_en});
		for (int c = 0; c < 7; c++)
		begin
			bus(1'b0, 12'h068, 8'h18 | c[2:0] | {1'b0, c[1:0], 5'h0}, 1'b1, q);
			chk("pump_en on", 32'h1, {31'h0, o_pump_en});
			chk("level", {30'h0, c[1:0]}, {30'h0, o_reg_level});
			pump_period(p);
			chk("pump period", (2 * HALF) << (7 - c), p);
		end
		// Reset in mid-run restores the power register
		i_rst_n <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_rst_n <= 1'b1;
		@(posedge i_clk);
		rd_chk(12'h068, 8'h7f);
		print_verdict();
	end
endmodule
